// >>> src/dsw_consts.svh
// Constants for the burst-of-two SRAM command and byte-write block
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH
`define DSW_BYTE_W      9
`define DSW_W_X9        9
`define DSW_W_X18       18
`define DSW_W_X36       36
`define DSW_ADDR_W_DEF  4
`define DSW_ADDR_W_MAX  8
`define DSW_MAX_LANES   4
`define DSW_LANE_IDLE   4'hF
`define DSW_LANE_ALL    4'h0
`define DSW_SYNC_RST    2'h0
`define DSW_BEAT_K      1'h0
`define DSW_BEAT_KN     1'h1
`endif

// >>> src/dsw_pkg.sv
// Types shared by the burst-of-two SRAM command and byte-write block
package dsw_pkg;
   typedef enum logic [1:0] {
      DSW_RUN   = 2'b00,
      DSW_DRAIN = 2'b01,
      DSW_HALT  = 2'b10
   } dsw_run_e;
endpackage

// >>> src/dsw_beat_if.sv
// Carrier between one write beat and its lane mask decoder
`timescale 1ns/1ns
interface dsw_beat_if #(
   parameter int DATA_W = 36
);
   logic [3:0]        lane_en_n;
   logic [DATA_W-1:0] bit_mask;
   modport src  (output lane_en_n, input  bit_mask);
   modport mask (input  lane_en_n, output bit_mask);
endinterface

// >>> src/dsw_lane_mask.sv
// Byte-lane enable to bit write mask decoder for one write beat
`timescale 1ns/1ns
`include "dsw_consts.svh"
module dsw_lane_mask #(
   parameter int DATA_W = 36
) (
   dsw_beat_if.mask bus
);
   localparam int LANES = DATA_W / `DSW_BYTE_W;

   if (DATA_W != `DSW_W_X9 && DATA_W != `DSW_W_X18 && DATA_W != `DSW_W_X36) begin : g_bad_w
      $error("dsw_lane_mask: DATA_W must be 9, 18 or 36");
   end

   // ------------------------------------------------------------
   // One active-low enable per nine-bit lane, lanes independent
   // ------------------------------------------------------------
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign bus.bit_mask[l*`DSW_BYTE_W +: `DSW_BYTE_W] = {`DSW_BYTE_W{~bus.lane_en_n[l]}};
   end
endmodule

// >>> src/dsw_top.sv
// Command decode, read burst pipeline and byte-write masking of the SRAM core
// Functional notes
// - Clock stopped holds inputs, outputs and operation
// - Pending bursts finish before stop takes hold
// - Both selects high means no operation, outputs off
// - Read: first beat next cycle, second after two
// - Write captures both beats in command cycle
// - Lane enables sampled separately for each beat
// - Lane enables ignored outside a write cycle
// - All enables low writes the whole word
// - x36 lanes 2,3 low write bytes 2,3
// - Lane 0 bits 0-8, lane 1 bits 9-17
// - Lane 2 bits 18-26, lane 3 bits 27-35
// - Both output clocks high: launch from input clock
`timescale 1ns/1ns
`include "dsw_consts.svh"
module dsw_top #(
   parameter int DATA_W = `DSW_W_X36,
   parameter int ADDR_W = `DSW_ADDR_W_DEF
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              rd_sel_n,
   input  wire logic              wr_sel_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata_k,
   input  wire logic [DATA_W-1:0] wdata_kn,
   input  wire logic [1:0]        lane0_write_enable_n,
   input  wire logic [1:0]        lane1_write_enable_n,
   input  wire logic [1:0]        lane2_write_enable_n,
   input  wire logic [1:0]        lane3_write_enable_n,
   input  wire logic [1:0]        single_lane_write_enable_n,
   input  wire logic              clk_stop,
   input  wire logic              out_clk_c,
   input  wire logic              out_clk_cn,
   output logic [DATA_W-1:0]      q_lo,
   output logic                   q_lo_oe,
   output logic [DATA_W-1:0]      q_hi,
   output logic                   q_hi_oe,
   output logic                   launch_from_k,
   output logic                   stopped
);
   localparam int WORDS = 2 ** (ADDR_W + 1);

   if (DATA_W != `DSW_W_X9 && DATA_W != `DSW_W_X18 && DATA_W != `DSW_W_X36) begin : g_bad_w
      $error("dsw_top: DATA_W must be 9, 18 or 36");
   end
   if (ADDR_W < 1 || ADDR_W > `DSW_ADDR_W_MAX) begin : g_bad_a
      $error("dsw_top: ADDR_W out of range");
   end

   typedef struct packed {
      logic [1:0]                   stop_sync;
      logic [1:0]                   c_sync;
      logic [1:0]                   cn_sync;
      logic [1:0]                   strap_fill;
      logic                         strap_done;
      logic                         launch_from_k;
      dsw_pkg::dsw_run_e            run;
      logic                         halted;
      logic                         rd_pend;
      logic [ADDR_W-1:0]            rd_addr;
      logic [DATA_W-1:0]            q_lo;
      logic                         q_lo_oe;
      logic [DATA_W-1:0]            q_hi;
      logic                         q_hi_oe;
      logic [WORDS-1:0][DATA_W-1:0] mem;
   } dsw_state_s;

   dsw_state_s cur;
   dsw_state_s next_cur;

   // ------------------------------------------------------------
   // Lane enables of each beat, decoded to bit masks
   // ------------------------------------------------------------
   dsw_beat_if #(.DATA_W(DATA_W)) beat0 ();
   dsw_beat_if #(.DATA_W(DATA_W)) beat1 ();

   // The single x9 enable stands in lane 0; unused lanes are idle
   assign beat0.lane_en_n = (DATA_W == `DSW_W_X9) ?
      {3'h7, single_lane_write_enable_n[`DSW_BEAT_K]} :
      {lane3_write_enable_n[`DSW_BEAT_K], lane2_write_enable_n[`DSW_BEAT_K],
       lane1_write_enable_n[`DSW_BEAT_K], lane0_write_enable_n[`DSW_BEAT_K]};
   assign beat1.lane_en_n = (DATA_W == `DSW_W_X9) ?
      {3'h7, single_lane_write_enable_n[`DSW_BEAT_KN]} :
      {lane3_write_enable_n[`DSW_BEAT_KN], lane2_write_enable_n[`DSW_BEAT_KN],
       lane1_write_enable_n[`DSW_BEAT_KN], lane0_write_enable_n[`DSW_BEAT_KN]};

   dsw_lane_mask #(.DATA_W(DATA_W)) u_mask0 (.bus(beat0.mask));
   dsw_lane_mask #(.DATA_W(DATA_W)) u_mask1 (.bus(beat1.mask));

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   logic              accept;
   logic              rd_take;
   logic              wr_take;
   logic              stop_seen;
   logic [ADDR_W:0]   w_idx0;
   logic [ADDR_W:0]   w_idx1;

   assign accept    = (cur.run == dsw_pkg::DSW_RUN);
   assign stop_seen = cur.stop_sync[1];
   assign rd_take   = accept && !rd_sel_n;
   assign wr_take   = accept && !wr_sel_n;
   assign w_idx0    = {addr, `DSW_BEAT_K};
   assign w_idx1    = {addr, `DSW_BEAT_KN};

   always_comb begin
      next_cur = cur;
      next_cur.stop_sync = {cur.stop_sync[0], clk_stop};
      next_cur.c_sync    = {cur.c_sync[0], out_clk_c};
      next_cur.cn_sync   = {cur.cn_sync[0], out_clk_cn};
      // The mode strap is taken once; switching it live is not supported
      // Wait for the synchronisers to refill after reset before taking it
      next_cur.strap_fill = {cur.strap_fill[0], 1'h1};
      if (cur.strap_fill[1] && !cur.strap_done) begin
         next_cur.strap_done    = 1'b1;
         next_cur.launch_from_k = cur.c_sync[1] && cur.cn_sync[1];
      end

      case (cur.run)
         dsw_pkg::DSW_RUN: begin
            // Second beat of the read taken last cycle
            next_cur.q_hi_oe = cur.rd_pend;
            if (cur.rd_pend) begin
               next_cur.q_hi = cur.mem[{cur.rd_addr, `DSW_BEAT_KN}];
            end
            next_cur.rd_pend = rd_take;
            next_cur.q_lo_oe = rd_take;
            if (rd_take) begin
               next_cur.rd_addr = addr;
               next_cur.q_lo    = cur.mem[w_idx0];
            end
            if (wr_take) begin
               next_cur.mem[w_idx0] = (cur.mem[w_idx0] & ~beat0.bit_mask) |
                                      (wdata_k & beat0.bit_mask);
               next_cur.mem[w_idx1] = (cur.mem[w_idx1] & ~beat1.bit_mask) |
                                      (wdata_kn & beat1.bit_mask);
            end
            if (stop_seen) begin
               next_cur.run = dsw_pkg::DSW_DRAIN;
            end
         end
         dsw_pkg::DSW_DRAIN: begin
            // Finish the open burst, then freeze everything
            if (cur.rd_pend) begin
               next_cur.q_hi    = cur.mem[{cur.rd_addr, `DSW_BEAT_KN}];
               next_cur.q_hi_oe = 1'b1;
               next_cur.q_lo_oe = 1'b0;
               next_cur.rd_pend = 1'b0;
            end else begin
               // Last beat is out: release the outputs, then freeze for the stop
               next_cur.q_lo_oe = 1'b0;
               next_cur.q_hi_oe = 1'b0;
               next_cur.run    = dsw_pkg::DSW_HALT;
               next_cur.halted = 1'b1;
            end
         end
         dsw_pkg::DSW_HALT: begin
            // Outputs and memory stand as they were
            if (!stop_seen) begin
               next_cur.run    = dsw_pkg::DSW_RUN;
               next_cur.halted = 1'b0;
            end
         end
         default: begin
            next_cur.run = dsw_pkg::DSW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cur               <= '0;
         cur.stop_sync     <= `DSW_SYNC_RST;
         cur.c_sync        <= `DSW_SYNC_RST;
         cur.cn_sync       <= `DSW_SYNC_RST;
         cur.run           <= dsw_pkg::DSW_RUN;
      end else begin
         cur <= next_cur;
      end
   end

   assign q_lo          = cur.q_lo;
   assign q_lo_oe       = cur.q_lo_oe;
   assign q_hi          = cur.q_hi;
   assign q_hi_oe       = cur.q_hi_oe;
   assign launch_from_k = cur.launch_from_k;
   assign stopped       = cur.halted;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking dsw_cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_read_taken;
      rd_take;
   endsequence

   sequence s_read_burst;
      q_lo_oe ##1 q_hi_oe;
   endsequence

   property p_read_beats;
      s_read_taken |=> s_read_burst;
   endproperty
   a_read_beats: assert property (p_read_beats) else $error("read burst beats misplaced");

   property p_read_word;
      rd_take |=> q_lo == $past(cur.mem[w_idx0]);
   endproperty
   a_read_word: assert property (p_read_word) else $error("first read beat wrong");

   property p_nop_off;
      accept && rd_sel_n && wr_sel_n && !cur.rd_pend |=> !q_lo_oe && !q_hi_oe;
   endproperty
   a_nop_off: assert property (p_nop_off) else $error("output on during no-op");

   property p_halt_hold;
      cur.halted && next_cur.halted |=> $stable(q_lo) && $stable(q_hi) &&
         $stable(q_lo_oe) && $stable(q_hi_oe) && $stable(cur.mem);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("state moved while stopped");

   property p_drain_finish;
      cur.run == dsw_pkg::DSW_DRAIN && cur.rd_pend |=> q_hi_oe ##1 stopped;
   endproperty
   a_drain_finish: assert property (p_drain_finish) else $error("burst not finished at stop");

   property p_no_write;
      !wr_take |=> $stable(cur.mem);
   endproperty
   a_no_write: assert property (p_no_write) else $error("memory written outside write");

   property p_full_write;
      wr_take && (beat0.lane_en_n == `DSW_LANE_ALL) && (DATA_W == `DSW_W_X36)
         |=> cur.mem[$past(w_idx0)] == $past(wdata_k);
   endproperty
   a_full_write: assert property (p_full_write) else $error("full word not written");

   property p_write_nothing;
      wr_take && (beat0.lane_en_n == `DSW_LANE_IDLE) && (beat1.lane_en_n == `DSW_LANE_IDLE)
         |=> $stable(cur.mem);
   endproperty
   a_write_nothing: assert property (p_write_nothing) else $error("idle lanes wrote");

   property p_release_off;
      accept && q_hi_oe && !cur.rd_pend |=> !q_hi_oe;
   endproperty
   a_release_off: assert property (p_release_off) else $error("outputs not released");
endmodule

// >>> bench/dsw_ctrl_model.sv
// Memory controller model that drives commands into the SRAM block
`timescale 1ns/1ns
module dsw_ctrl_model (
   input  wire logic   clk,
   output logic        rd_sel_n,
   output logic        wr_sel_n,
   output logic [3:0]  addr,
   output logic [35:0] wdata_k,
   output logic [35:0] wdata_kn,
   output logic [7:0]  lane_en_n
);
   initial begin
      {rd_sel_n, wr_sel_n, addr, lane_en_n} = 14'h3FFF;
      {wdata_k, wdata_kn} = 72'h0;
   end
   // One command cycle; data and enables of both beats travel with it
   task automatic cmd(input logic r, input logic w, input logic [3:0] a,
                      input logic [35:0] d0, input logic [35:0] d1, input logic [7:0] e);
      @(posedge clk);
      rd_sel_n  <= r;
      wr_sel_n  <= w;
      addr      <= a;
      wdata_k   <= d0;
      wdata_kn  <= d1;
      lane_en_n <= e;
      @(posedge clk);
      rd_sel_n  <= 1'h1;
      wr_sel_n  <= 1'h1;
      // Released lines flip so a stale word cannot pass for a capture
      wdata_k   <= ~d0;
      wdata_kn  <= ~d1;
      lane_en_n <= 8'hFF;
   endtask
endmodule

// >>> bench/ddr_sram_cmd_byte_write_tb.sv
// Self-checking bench for the SRAM command and byte-write block
`timescale 1ns/1ns
module ddr_sram_cmd_byte_write_tb;
   logic        clk, nrst, clk_stop, oc_c, oc_cn, rs_n, ws_n;
   logic        q_lo_oe, q_hi_oe, launch_from_k, stopped;
   logic [3:0]  addr;
   logic [7:0]  en_n;
   logic [35:0] wk, wkn, q_lo, q_hi;
   logic        q9_lo_oe, q9_hi_oe, lk9, st9;
   logic [8:0]  q9_lo, q9_hi;
   logic [35:0] exp_mem [0:31];
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          i;
   dsw_ctrl_model m (.clk(clk), .rd_sel_n(rs_n), .wr_sel_n(ws_n), .addr(addr),
                     .wdata_k(wk), .wdata_kn(wkn), .lane_en_n(en_n));
   dsw_top #(.DATA_W(36), .ADDR_W(4)) dut (.clk(clk), .nrst(nrst), .rd_sel_n(rs_n),
      .wr_sel_n(ws_n), .addr(addr), .wdata_k(wk), .wdata_kn(wkn),
      .lane0_write_enable_n(en_n[1:0]), .lane1_write_enable_n(en_n[3:2]),
      .lane2_write_enable_n(en_n[5:4]), .lane3_write_enable_n(en_n[7:6]),
      .single_lane_write_enable_n(2'h3), .clk_stop(clk_stop), .out_clk_c(oc_c),
      .out_clk_cn(oc_cn), .q_lo(q_lo), .q_lo_oe(q_lo_oe), .q_hi(q_hi),
      .q_hi_oe(q_hi_oe), .launch_from_k(launch_from_k), .stopped(stopped));
   // Nine-bit twin on the same command lines; its one enable follows lane 0
   dsw_top #(.DATA_W(9), .ADDR_W(4)) dut_x9 (.clk(clk), .nrst(nrst), .rd_sel_n(rs_n),
      .wr_sel_n(ws_n), .addr(addr), .wdata_k(wk[8:0]), .wdata_kn(wkn[8:0]),
      .lane0_write_enable_n(2'h3), .lane1_write_enable_n(2'h3),
      .lane2_write_enable_n(2'h3), .lane3_write_enable_n(2'h3),
      .single_lane_write_enable_n(en_n[1:0]), .clk_stop(clk_stop), .out_clk_c(oc_c),
      .out_clk_cn(oc_cn), .q_lo(q9_lo), .q_lo_oe(q9_lo_oe), .q_hi(q9_hi),
      .q_hi_oe(q9_hi_oe), .launch_from_k(lk9), .stopped(st9));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic chk(input logic [35:0] got, input logic [35:0] want);
      cmp_count++;
      if (got !== want) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic chkb(input logic got, input logic want);
      chk({35'h0, got}, {35'h0, want});
   endtask
   task automatic clr_exp();
      for (int k = 0; k < 32; k++) exp_mem[k] = 36'h0;
   endtask
   // Byte lane n of beat b is written when its enable bit is low
   task automatic wr(input logic [3:0] a, input logic [35:0] d0, input logic [35:0] d1,
                     input logic [7:0] e);
      m.cmd(1'h1, 1'h0, a, d0, d1, e);
      for (int n = 0; n < 4; n++) begin
         if (!e[2*n]) exp_mem[{a, 1'h0}][9*n+:9] = d0[9*n+:9];
         if (!e[2*n+1]) exp_mem[{a, 1'h1}][9*n+:9] = d1[9*n+:9];
      end
   endtask
   task automatic rd(input logic [3:0] a);
      m.cmd(1'h0, 1'h1, a, 36'h0, 36'h0, 8'hFF);
      #1 chk(q_lo, exp_mem[{a, 1'h0}]);
      chk({27'h0, q9_lo}, {27'h0, exp_mem[{a, 1'h0}][8:0]});
      chkb(q_lo_oe, 1'h1);
      chkb(q9_lo_oe, 1'h1);
      @(posedge clk) #1 chk(q_hi, exp_mem[{a, 1'h1}]);
      chk({27'h0, q9_hi}, {27'h0, exp_mem[{a, 1'h1}][8:0]});
      chkb(q_hi_oe, 1'h1);
      chkb(q_lo_oe, 1'h0);
      @(posedge clk) #1 chkb(q_hi_oe, 1'h0);
      chkb(q9_hi_oe, 1'h0);
   endtask
   task automatic wait_stop(input logic lvl);
      i = 0;
      while (stopped !== lvl && i < 10) begin
         @(posedge clk) #1 i++;
      end
      chkb(stopped, lvl);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_rw();
      rd(4'h5);
      wr(4'h2, 36'h1_2345_6789, 36'h9_8765_4321, 8'h00);
      wr(4'h3, 36'hF_0F0F_0F0F, 36'h0_F0F0_F0F0, 8'h00);
      rd(4'h2);
      rd(4'h3);
      $display("test rw done");
   endtask
   task automatic test_lanes();
      logic [7:0] tbl [0:5];
      tbl = '{8'h00, 8'hFC, 8'hF3, 8'h0F, 8'hFF, 8'h7E};
      for (int k = 0; k < 6; k++) begin
         wr(4'h8 + k, 36'h5_5555_5555, 36'h5_5555_5555, 8'h00);
         wr(4'h8 + k, 36'hA_AAAA_AAAA, 36'h3_3333_3333, tbl[k]);
         rd(4'h8 + k);
      end
      $display("test lanes done");
   endtask
   task automatic test_ignore();
      m.cmd(1'h1, 1'h1, 4'h3, 36'h0, 36'h0, 8'h00);
      #1 chkb(q_lo_oe, 1'h0);
      rd(4'h3);
      $display("test ignore done");
   endtask
   task automatic test_stop();
      @(posedge clk) clk_stop <= 1'h1;
      // The read lands on the edge that first sees the stop, so drain must finish it
      @(posedge clk);
      rd(4'h2);
      wait_stop(1'h1);
      m.cmd(1'h1, 1'h0, 4'h2, 36'h0, 36'h0, 8'h00);
      repeat (3) @(posedge clk);
      #1 chkb(stopped, 1'h1);
      chkb(st9, 1'h1);
      chk(q_hi, exp_mem[5]);
      @(posedge clk) clk_stop <= 1'h0;
      wait_stop(1'h0);
      rd(4'h2);
      $display("test stop done");
   endtask
   task automatic test_single();
      @(posedge clk);
      nrst <= 1'h0;
      oc_c <= 1'h1;
      oc_cn <= 1'h1;
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      repeat (3) @(posedge clk);
      #1 chkb(launch_from_k, 1'h1);
      chkb(lk9, 1'h1);
      clr_exp();
      rd(4'h2);
      $display("test single done");
   endtask
   initial begin
      {nrst, clk_stop, oc_c, oc_cn} = 4'h0;
      clr_exp();
      repeat (12) @(posedge clk);
      nrst <= 1'h1;
      test_rw();
      test_lanes();
      test_ignore();
      test_stop();
      test_single();
      print_verdict();
   end
endmodule
